// ### bench/hbu_emu_model.sv
// Debug emulator model: Avalon-MM master toward the breakpoint unit.
// Assumes waitrequest is sampled at rising edges of i_clk.
`timescale 1ns/1ps
module hbu_emu_model (
    input wire logic i_clk,
    input wire logic i_wait,
    input wire logic [31:0] i_rdata,
    output logic [7:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [31:0] o_wdata
);
    logic [31:0] last_q;
    initial begin
        o_addr = 8'h00;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wr <= w;
        o_rd <= !w;
        o_wdata <= d;
        @(posedge i_clk iff !i_wait);
        last_q = i_rdata;
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // Write then read back and compare
    task automatic wrv(input logic [7:0] a, input logic [31:0] d, output logic ok);
        xfer(1'b1, a, d);
        xfer(1'b0, a, d);
        ok = (last_q === d);
    endtask
endmodule

// ### bench/hbu_top_properties.sv
// Port-level checks for the breakpoint unit top.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module hbu_top_properties (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input hbu_pkg::hbu_access_s i_first_data_address_generator,
    input hbu_pkg::hbu_access_s i_data_memory_modifier,
    input hbu_pkg::hbu_access_s i_second_data_address_generator,
    input hbu_pkg::hbu_access_s i_program_memory_modifier,
    input hbu_pkg::hbu_access_s i_io_bus,
    input hbu_pkg::hbu_access_s i_external_memory_port,
    input hbu_pkg::hbu_access_s i_instr_exec,
    input wire logic i_port_empty_read,
    input wire logic i_port_full_write,
    input wire logic o_core_stall,
    input wire logic o_abort_stalled,
    input wire logic o_halt
);
    import hbu_pkg::*;
    logic acc_any;
    assign acc_any = i_first_data_address_generator.valid | i_data_memory_modifier.valid
        | i_second_data_address_generator.valid | i_program_memory_modifier.valid
        | i_io_bus.valid | i_external_memory_port.valid | i_instr_exec.valid;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    chk_stall_follows_ports:
        assert property (o_core_stall == (i_port_empty_read | i_port_full_write))
        else $error("stall differs from port hazards");
    chk_abort_after_ctrl:
        assert property ($rose(o_abort_stalled) |-> $past(i_avs_write && !o_avs_waitrequest
            && i_avs_address == REG_CTRL))
        else $error("abort rose without a control write");
    chk_halt_after_access:
        assert property ($rose(o_halt) |-> ($past(acc_any, 2) || $past(acc_any, 3)
            || $past(acc_any, 4) || $past(acc_any, 5)))
        else $error("halt without access two or more cycles before");
    chk_halt_stays_up:
        assert property (o_halt && !(i_avs_write && !o_avs_waitrequest
            && i_avs_address == REG_STATUS) |=> o_halt)
        else $error("halt dropped without resume");
    chk_reset_clears_out:
        assert property ($fell(i_sys_rst) |-> !o_halt && !o_abort_stalled)
        else $error("outputs set after reset");
    chk_wait_first_cycle:
        assert property ((i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write)
            |-> o_avs_waitrequest)
        else $error("no wait state on new request");
    chk_wait_one_cycle:
        assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
            |=> !o_avs_waitrequest)
        else $error("wait state longer than one cycle");
    chk_unmapped_reads_zero:
        assert property (i_avs_read && !o_avs_waitrequest && i_avs_address > REG_CMP_LAST
            |-> o_avs_readdata == RD_ZERO)
        else $error("unmapped read not zero");
endmodule
bind hbu_top hbu_top_properties chk_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_first_data_address_generator(i_first_data_address_generator),
    .i_data_memory_modifier(i_data_memory_modifier),
    .i_second_data_address_generator(i_second_data_address_generator),
    .i_program_memory_modifier(i_program_memory_modifier), .i_io_bus(i_io_bus),
    .i_external_memory_port(i_external_memory_port), .i_instr_exec(i_instr_exec),
    .i_port_empty_read(i_port_empty_read), .i_port_full_write(i_port_full_write),
    .o_core_stall(o_core_stall), .o_abort_stalled(o_abort_stalled), .o_halt(o_halt)
);

// ### bench/hbu_top_tb.sv
// Self-checking bench for the breakpoint unit top.
// Assumes the emulator model and the checker are compiled before it.
`timescale 1ns/1ps
module hbu_top_tb;
    import hbu_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wait_r;
    hbu_access_s bus_q [7];
    logic empty_q;
    logic full_q;
    logic stall;
    logic abort;
    logic halt;
    logic ok;
    int mismatches = 0;
    int checks = 0;
    always #20 i_clk = ~i_clk;
    hbu_emu_model emu_u (.i_clk(i_clk), .i_wait(wait_r), .i_rdata(rdata), .o_addr(addr),
        .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
    hbu_top dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_r), .i_first_data_address_generator(bus_q[0]),
        .i_data_memory_modifier(bus_q[1]), .i_second_data_address_generator(bus_q[2]),
        .i_program_memory_modifier(bus_q[3]), .i_io_bus(bus_q[4]),
        .i_external_memory_port(bus_q[5]), .i_instr_exec(bus_q[6]),
        .i_port_empty_read(empty_q), .i_port_full_write(full_q), .o_core_stall(stall),
        .o_abort_stalled(abort), .o_halt(halt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        emu_u.xfer(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        emu_u.xfer(1'b0, a, e);
        chk(emu_u.last_q, e);
    endtask
    // Program start, end and config of comparator n, each verified
    task automatic cfg(input int n, input logic [31:0] s, input logic [31:0] e,
        input logic [3:0] c);
        emu_u.wrv(8'(16 * n + 16), s, ok);
        chk({31'h0, ok}, 32'h1);
        emu_u.wrv(8'(16 * n + 20), e, ok);
        chk({31'h0, ok}, 32'h1);
        emu_u.wrv(8'(16 * n + 24), {28'h0, c}, ok);
        chk({31'h0, ok}, 32'h1);
    endtask
    // One-cycle access on the buses in mask m, then halt check and resume
    task automatic ev(input logic [6:0] m, input logic [31:0] a, input logic [1:0] rw,
        input logic e);
        int n;
        n = 0;
        @(posedge i_clk);
        for (int i = 0; i < 7; i++) begin
            if (m[i]) bus_q[i] <= '{1'b1, rw[1], rw[0], a};
        end
        @(posedge i_clk);
        for (int i = 0; i < 7; i++) bus_q[i] <= '{1'b0, rw[0], rw[1], ~a};
        repeat (6) begin
            @(posedge i_clk);
            if (halt !== 1'b1) n++;
        end
        chk({31'h0, halt}, {31'h0, e});
        chk(32'(n), e ? 32'(LATENCY + 1) : 32'h6);
        if (halt === 1'b1) wr_reg(REG_STATUS, 32'h1);
    endtask
    initial begin
        #(40 * 30000);
        mismatches++;
        complete_run();
    end
    initial begin
        bus_q = '{default: '0};
        empty_q = 1'b0;
        full_q = 1'b0;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd_chk(REG_CTRL, RD_ZERO);
        rd_chk(REG_STATUS, RD_ZERO);
        wr_reg(8'ha0, 32'hffff_ffff);
        rd_chk(8'ha0, RD_ZERO);
        $display("test registers done");
        cfg(0, 32'h100, 32'h1ff, 4'hd);
        ev(7'h01, 32'h1ff, 2'b01, 1'b1);
        ev(7'h01, 32'h200, 2'b01, 1'b0);
        ev(7'h02, 32'h100, 2'b10, 1'b1);
        cfg(1, 32'h300, 32'h300, 4'hd);
        ev(7'h02, 32'h301, 2'b10, 1'b0);
        ev(7'h01, 32'h300, 2'b10, 1'b1);
        cfg(0, 32'h100, 32'h1ff, 4'hc);
        ev(7'h01, 32'h150, 2'b01, 1'b0);
        for (int m = 0; m < 4; m++) begin
            cfg(CMP_IO, 32'h40, 32'h40, {2'(m), 2'b01});
            ev(7'h10, 32'h40, 2'b01, 1'(m));
            ev(7'h10, 32'h40, 2'b10, 1'(m >> 1));
        end
        cfg(CMP_EXT, 32'h1000, 32'h1fff, 4'hf);
        ev(7'h20, 32'h1800, 2'b01, 1'b0);
        ev(7'h20, 32'h2000, 2'b10, 1'b1);
        cfg(5, 32'h80, 32'h8f, 4'h1);
        ev(7'h40, 32'h8f, 2'b00, 1'b1);
        ev(7'h40, 32'h90, 2'b00, 1'b0);
        cfg(CMP_PMD, 32'h500, 32'h5ff, 4'hd);
        ev(7'h04, 32'h500, 2'b01, 1'b1);
        ev(7'h08, 32'h5ff, 2'b10, 1'b1);
        ev(7'h01, 32'h500, 2'b01, 1'b0);
        $display("test comparators done");
        wr_reg(REG_SKIP, 32'h2);
        ev(7'h04, 32'h500, 2'b01, 1'b0);
        ev(7'h04, 32'h500, 2'b01, 1'b0);
        ev(7'h04, 32'h500, 2'b01, 1'b1);
        rd_chk(REG_SKIP_CUR, 32'h0);
        wr_reg(REG_CTRL, 32'h2);
        wr_reg(REG_SKIP, 32'h1);
        ev(7'h04, 32'h500, 2'b01, 1'b0);
        ev(7'h04, 32'h500, 2'b01, 1'b1);
        rd_chk(REG_SKIP_CUR, 32'h1);
        rd_chk(REG_SKIP, 32'h1);
        wr_reg(REG_SKIP, 32'h0);
        $display("test skip done");
        for (int n = 0; n < NUM_CMP; n++) cfg(n, 32'h0, 32'h0, 4'h0);
        cfg(0, 32'h100, 32'h1ff, 4'hd);
        cfg(CMP_INSTR0, 32'h100, 32'h1ff, 4'h1);
        wr_reg(REG_CTRL, 32'h1);
        ev(7'h01, 32'h150, 2'b01, 1'b0);
        ev(7'h41, 32'h150, 2'b01, 1'b1);
        wr_reg(REG_CTRL, 32'h0);
        ev(7'h01, 32'h150, 2'b01, 1'b1);
        $display("test combine done");
        empty_q <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk({31'h0, stall}, 32'h1);
        chk({31'h0, abort}, 32'h0);
        wr_reg(REG_CTRL, 32'h4);
        repeat (2) @(posedge i_clk);
        chk({31'h0, abort}, 32'h1);
        rd_chk(REG_STATUS, 32'h2);
        empty_q <= 1'b0;
        full_q <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk({31'h0, stall}, 32'h1);
        full_q <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk({31'h0, abort}, 32'h0);
        chk({31'h0, stall}, 32'h0);
        $display("test hang done");
        complete_run();
    end
endmodule

// ### hdl/hbu_cmp.sv
// One address range comparator with enable, exclusive and access qualifier.
// Assumes access strobes are synchronous to i_clk.
`timescale 1ns/1ps
module hbu_cmp (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input hbu_pkg::hbu_cmp_cfg_s i_cfg,
    input hbu_pkg::hbu_access_s i_acc,
    input wire logic i_qualified,
    output logic o_match
);
    import hbu_pkg::*;
    logic in_range;
    logic kind_ok;
    logic match_d;
    logic match_q;

    always_comb begin
        // Both limits included
        in_range = (i_acc.addr >= i_cfg.start_addr) && (i_acc.addr <= i_cfg.end_addr); // [R2]
        if (!i_qualified) begin
            kind_ok = i_acc.valid;
        end else begin
            case (i_cfg.mode) // [R4]
                HBU_MODE_WR: kind_ok = i_acc.valid && i_acc.wr;
                HBU_MODE_RD: kind_ok = i_acc.valid && i_acc.rd;
                HBU_MODE_ANY: kind_ok = i_acc.valid && (i_acc.rd || i_acc.wr);
                default: kind_ok = 1'b0;
            endcase
        end
        match_d = i_cfg.en && kind_ok && (in_range ^ i_cfg.excl); // [R1] [R3]
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_d;
        end
    end

    assign o_match = match_q;
endmodule

// ### hdl/hbu_regs.sv
// Comparator configuration store: one word per field per comparator.
// Read data are registered; writes take one cycle.
`timescale 1ns/1ps
module hbu_regs (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr,
    input wire logic [hbu_pkg::CMP_IDX_W-1:0] i_idx,
    input wire logic [1:0] i_field,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    output hbu_pkg::hbu_cmp_cfg_s o_cfg [hbu_pkg::NUM_CMP]
);
    import hbu_pkg::*;
    hbu_cmp_cfg_s cfg_q [NUM_CMP];
    hbu_cmp_cfg_s cfg_d [NUM_CMP];
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_comb begin
        rdata_d = RD_ZERO;
        for (int i = 0; i < NUM_CMP; i++) begin
            cfg_d[i] = cfg_q[i];
            if (i_idx == CMP_IDX_W'(i)) begin
                if (i_field == CMP_OFS_START) begin
                    rdata_d = cfg_q[i].start_addr;
                end else if (i_field == CMP_OFS_END) begin
                    rdata_d = cfg_q[i].end_addr;
                end else if (i_field == CMP_OFS_CFG) begin
                    rdata_d = {28'h0, cfg_q[i].mode, cfg_q[i].excl, cfg_q[i].en};
                end
                if (i_wr) begin
                    if (i_field == CMP_OFS_START) begin
                        cfg_d[i].start_addr = i_wdata;
                    end else if (i_field == CMP_OFS_END) begin
                        cfg_d[i].end_addr = i_wdata;
                    end else if (i_field == CMP_OFS_CFG) begin
                        cfg_d[i].en = i_wdata[CFG_EN];
                        cfg_d[i].excl = i_wdata[CFG_EXCL];
                        cfg_d[i].mode = hbu_mode_e'(i_wdata[CFG_MODE_LSB +: 2]);
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        rdata_q <= rdata_d;
        for (int i = 0; i < NUM_CMP; i++) begin
            if (i_sys_rst) begin
                cfg_q[i] <= '0;
            end else begin
                cfg_q[i] <= cfg_d[i];
            end
        end
    end

    assign o_rdata = rdata_q;
    assign o_cfg = cfg_q;
endmodule

// ### hdl/hbu_top.sv
// Hardware breakpoint unit top: bus slave, comparators, combine, skip, halt, hang abort.
// Assumes core access buses synchronous to i_clk, one access per cycle per bus.
//
// Summary of operation
// R1: Each comparator has its own enable
// R2: Match when address within inclusive range
// R3: Exclusive option matches outside the range
// R4: Qualifier modes: off, write, read, any
// R5: Skip counter decrements; halt only at zero
// R6: Restore option reloads skip count after break
// R7: Groups ORed, or ANDed when selected
// R8: Data comparators watch first generator, data modifier
// R9: Two data comparators ORed together
// R10: Four instruction comparators ORed together
// R11: Program data comparator watches second generator
// R12: IO comparator watches the IO address bus
// R13: External port comparator watches port accesses
// R14: Break asserts two cycles after condition; the code raises o_halt three cycles after cond
// R15: Debugger traps one address with start=end
// R16: Debugger avoids illegal breakpoint locations
// R17: Empty or full peripheral port stalls core
// R18: Abort control kills the stalled instruction
// R19: Emulator verifies writes by reading back
// R20: Emulator clears cycle counters before run
// R21: Skip count zero halts on first event
`timescale 1ns/1ps
module hbu_top (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input hbu_pkg::hbu_access_s i_first_data_address_generator,
    input hbu_pkg::hbu_access_s i_data_memory_modifier,
    input hbu_pkg::hbu_access_s i_second_data_address_generator,
    input hbu_pkg::hbu_access_s i_program_memory_modifier,
    input hbu_pkg::hbu_access_s i_io_bus,
    input hbu_pkg::hbu_access_s i_external_memory_port,
    input hbu_pkg::hbu_access_s i_instr_exec,
    input wire logic i_port_empty_read,
    input wire logic i_port_full_write,
    output logic o_core_stall,
    output logic o_abort_stalled,
    output logic o_halt
);
    import hbu_pkg::*;

    hbu_cmp_cfg_s cfg [NUM_CMP];
    hbu_access_s acc [NUM_CMP];
    hbu_access_s data_acc;
    hbu_access_s pmd_acc;
    logic [NUM_CMP-1:0] match;
    logic [31:0] mem_rdata;

    // Bus slave state
    logic ack_q;
    logic ack_d;
    logic is_cmp;
    logic mem_wr;
    logic [7:0] rel;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // Control state
    logic and_all_q;
    logic and_all_d;
    logic restore_q;
    logic restore_d;
    logic abort_q;
    logic abort_d;
    logic [SKIP_W-1:0] skip_init_q;
    logic [SKIP_W-1:0] skip_init_d;
    logic [SKIP_W-1:0] skip_q;
    logic [SKIP_W-1:0] skip_d;
    logic [LATENCY-1:0] pipe_q;
    logic [LATENCY-1:0] pipe_d;
    hbu_state_e state_q;
    hbu_state_e state_d;

    logic data_grp;
    logic instr_grp;
    logic any_en;
    logic cond;
    logic hung;

    // Data and program data monitors see either source
    always_comb begin
        data_acc = i_first_data_address_generator.valid
            ? i_first_data_address_generator : i_data_memory_modifier; // [R8]
        pmd_acc = i_second_data_address_generator.valid
            ? i_second_data_address_generator : i_program_memory_modifier; // [R11]
    end

    generate
        for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
            if (g < CMP_INSTR0) begin : g_d
                assign acc[g] = data_acc;
            end else if (g < CMP_PMD) begin : g_i
                assign acc[g] = i_instr_exec; // [R10]
            end else if (g == CMP_PMD) begin : g_p
                assign acc[g] = pmd_acc;
            end else if (g == CMP_IO) begin : g_o
                assign acc[g] = i_io_bus; // [R12]
            end else begin : g_e
                assign acc[g] = i_external_memory_port; // [R13]
            end
            hbu_cmp u_cmp (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_cfg(cfg[g]),
                .i_acc(acc[g]),
                .i_qualified((g < CMP_INSTR0) || (g >= CMP_PMD)),
                .o_match(match[g])
            );
        end
    endgenerate

    assign rel = i_avs_address - REG_CMP_BASE;
    assign is_cmp = (i_avs_address >= REG_CMP_BASE) && (i_avs_address <= REG_CMP_LAST);
    // Writes land only at the edge where waitrequest is low
    assign mem_wr = i_avs_write && is_cmp && ack_q;

    hbu_regs u_regs (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr(mem_wr),
        .i_idx(rel[7:4]),
        .i_field(rel[3:2]),
        .i_wdata(i_avs_writedata),
        .o_rdata(mem_rdata),
        .o_cfg(cfg)
    );

    // Group combine: each group is the OR of its enabled members
    always_comb begin
        data_grp = |match[CMP_INSTR0-1:CMP_DATA0]; // [R9]
        instr_grp = |match[CMP_PMD-1:CMP_INSTR0]; // [R10]
        any_en = 1'b0;
        for (int i = 0; i < NUM_CMP; i++) begin
            any_en = any_en | cfg[i].en;
        end
        if (and_all_q) begin
            // Only enabled groups take part in the AND
            cond = any_en; // [R7]
            if ((cfg[0].en || cfg[1].en) && !data_grp) cond = 1'b0;
            if ((cfg[2].en || cfg[3].en || cfg[4].en || cfg[5].en) && !instr_grp) cond = 1'b0;
            if (cfg[CMP_PMD].en && !match[CMP_PMD]) cond = 1'b0;
            if (cfg[CMP_IO].en && !match[CMP_IO]) cond = 1'b0;
            if (cfg[CMP_EXT].en && !match[CMP_EXT]) cond = 1'b0;
        end else begin
            cond = data_grp | instr_grp | (|match[NUM_CMP-1:CMP_PMD]); // [R7]
        end
    end

    // Skip count, latency pipe and halt sequencer
    always_comb begin
        skip_d = skip_q;
        pipe_d = {pipe_q[LATENCY-2:0], 1'b0};
        state_d = state_q;
        case (state_q)
            HBU_ST_RUN: begin
                if (cond) begin
                    if (skip_q == '0) begin // [R5] [R21]
                        pipe_d[0] = 1'b1;
                        state_d = HBU_ST_PEND;
                    end else begin
                        skip_d = skip_q - 1'b1; // [R5]
                    end
                end
            end
            HBU_ST_PEND: begin
                if (pipe_q[LATENCY-1]) begin // [R14]
                    state_d = HBU_ST_HALT;
                    if (restore_q) begin
                        skip_d = skip_init_q; // [R6]
                    end
                end
            end
            default: begin
                pipe_d = '0;
            end
        endcase
        if (i_avs_write && ack_q && i_avs_address == REG_SKIP) begin
            skip_d = i_avs_writedata[SKIP_W-1:0];
        end
        // Writing status with halt bit set resumes the core
        if (i_avs_write && ack_q && i_avs_address == REG_STATUS &&
                i_avs_writedata[STAT_HALT]) begin
            state_d = HBU_ST_RUN;
            pipe_d = '0;
        end
    end

    // Hang handling
    assign hung = i_port_empty_read | i_port_full_write;
    assign o_core_stall = hung; // [R17]
    assign o_abort_stalled = abort_q & hung; // [R18]

    // Bus slave: one wait state; writes take effect with the answer
    always_comb begin
        ack_d = (i_avs_read || i_avs_write) && !ack_q;
        and_all_d = and_all_q;
        restore_d = restore_q;
        abort_d = abort_q & hung;
        skip_init_d = skip_init_q;
        rdata_d = RD_ZERO;
        if (i_avs_write && ack_q) begin
            if (i_avs_address == REG_CTRL) begin
                and_all_d = i_avs_writedata[CTRL_AND_ALL];
                restore_d = i_avs_writedata[CTRL_RESTORE];
                abort_d = i_avs_writedata[CTRL_ABORT]; // [R18]
            end else if (i_avs_address == REG_SKIP) begin
                skip_init_d = i_avs_writedata[SKIP_W-1:0];
            end
        end
        if (i_avs_address == REG_CTRL) begin
            rdata_d = {29'h0, abort_q, restore_q, and_all_q};
        end else if (i_avs_address == REG_SKIP) begin
            rdata_d = {16'h0, skip_init_q};
        end else if (i_avs_address == REG_STATUS) begin
            rdata_d = {30'h0, hung, state_q == HBU_ST_HALT};
        end else if (i_avs_address == REG_SKIP_CUR) begin
            rdata_d = {16'h0, skip_q};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ack_q <= 1'b0;
            and_all_q <= 1'b0;
            restore_q <= 1'b0;
            abort_q <= 1'b0;
            skip_init_q <= '0;
            skip_q <= '0;
            pipe_q <= '0;
            state_q <= HBU_ST_RUN;
            rdata_q <= RD_ZERO;
        end else begin
            ack_q <= ack_d;
            and_all_q <= and_all_d;
            restore_q <= restore_d;
            abort_q <= abort_d;
            skip_init_q <= skip_init_d;
            skip_q <= skip_d;
            pipe_q <= pipe_d;
            state_q <= state_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
    assign o_avs_readdata = is_cmp ? mem_rdata : rdata_q;
    assign o_halt = (state_q == HBU_ST_HALT);
endmodule

// ### inc/hbu_pkg.sv
// Package for the hardware breakpoint unit: register map, field layout, types.
// Assumes a 32-bit Avalon-MM slave with word addressing of byte offsets.
package hbu_pkg;
    localparam int ADDR_W = 32;
    localparam int NUM_DATA = 2;
    localparam int NUM_INSTR = 4;
    localparam int NUM_CMP = 9;
    // Comparator index order: data 0-1, instruction 2-5, pm data 6, io 7, ext port 8
    localparam int CMP_DATA0 = 0;
    localparam int CMP_INSTR0 = 2;
    localparam int CMP_PMD = 6;
    localparam int CMP_IO = 7;
    localparam int CMP_EXT = 8;
    localparam int CMP_IDX_W = 4;

    // Register map (byte offsets); each comparator uses a block of 16 bytes
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SKIP = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_SKIP_CUR = 8'h0c;
    localparam logic [7:0] REG_CMP_BASE = 8'h10;
    localparam logic [7:0] REG_CMP_LAST = 8'h9f;
    localparam logic [1:0] CMP_OFS_START = 2'h0;
    localparam logic [1:0] CMP_OFS_END = 2'h1;
    localparam logic [1:0] CMP_OFS_CFG = 2'h2;

    // Control register fields
    localparam int CTRL_AND_ALL = 0;
    localparam int CTRL_RESTORE = 1;
    localparam int CTRL_ABORT = 2;
    // Status register fields
    localparam int STAT_HALT = 0;
    localparam int STAT_HUNG = 1;
    // Comparator config fields
    localparam int CFG_EN = 0;
    localparam int CFG_EXCL = 1;
    localparam int CFG_MODE_LSB = 2;

    localparam int SKIP_W = 16;
    localparam int LATENCY = 2;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        HBU_MODE_OFF = 2'h0,
        HBU_MODE_WR = 2'h1,
        HBU_MODE_RD = 2'h2,
        HBU_MODE_ANY = 2'h3
    } hbu_mode_e;

    typedef struct packed {
        logic [ADDR_W-1:0] start_addr;
        logic [ADDR_W-1:0] end_addr;
        logic en;
        logic excl;
        hbu_mode_e mode;
    } hbu_cmp_cfg_s;

    typedef struct packed {
        logic valid;
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
    } hbu_access_s;

    // Gray-coded halt sequencer states
    typedef enum logic [1:0] {
        HBU_ST_RUN = 2'b00,
        HBU_ST_PEND = 2'b01,
        HBU_ST_HALT = 2'b11
    } hbu_state_e;
endpackage
